/* hdl/itc_pkg.sv */
// Constants shared by the interval time counter design
`default_nettype none
package itc_pkg;
	// ==========================================
	// Register addresses
	localparam logic [7:0] ITC_ADDR_CTRL = 8'hA1;
	localparam logic [7:0] ITC_ADDR_FRAC = 8'hA2;
	localparam logic [7:0] ITC_ADDR_SEC = 8'hA3;
	localparam logic [7:0] ITC_ADDR_MIN = 8'hA4;
	localparam logic [7:0] ITC_ADDR_HOUR = 8'hA5;
	localparam logic [7:0] ITC_ADDR_TARGET = 8'hA6;

	// ==========================================
	// Control field positions
	localparam int ITC_BIT_TIME_CLOCK_EN = 0;
	localparam int ITC_BIT_INTERVAL_COUNT_EN = 1;
	localparam int ITC_BIT_FLAG = 2;
	localparam int ITC_BIT_SHOT = 3;
	localparam int ITC_BIT_SEL_LO = 4;
	localparam int ITC_BIT_SEL_HI = 5;

	// ==========================================
	// Reset values
	localparam logic [7:0] ITC_RST_CTRL = 8'h00;
	localparam logic [7:0] ITC_RST_TIME = 8'h00;
	localparam logic [7:0] ITC_RST_TARGET = 8'h00;

	// ==========================================
	// Counter limits
	localparam logic [7:0] ITC_MAX_FRAC = 8'h7F;
	localparam logic [7:0] ITC_MAX_SEC = 8'h3B;
	localparam logic [7:0] ITC_MAX_MIN = 8'h3B;
	localparam logic [7:0] ITC_MAX_HOUR = 8'h17;

	// ==========================================
	// Timing
	localparam int ITC_CLK_NS = 10;
	localparam int ITC_TICK_NS = 7812500;
	localparam int ITC_TICK_CYC = ITC_TICK_NS / ITC_CLK_NS;

	// Interrupt entry address
	localparam logic [15:0] ITC_IRQ_VECTOR = 16'h0053;

	// ==========================================
	// Timebase selection
	typedef enum logic [1:0] {
		ITC_BASE_FRAC = 2'b00,
		ITC_BASE_SEC = 2'b01,
		ITC_BASE_MIN = 2'b10,
		ITC_BASE_HOUR = 2'b11
	} itc_base_e;
endpackage : itc_pkg
`default_nettype wire

/* hdl/itc_tick_div.sv */
// Divider making the 1/128 second enable pulse
`default_nettype none
module itc_tick_div import itc_pkg::*; #(
	parameter int CYCLES = ITC_TICK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	output logic tick
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// ==========================================
	// Divider
	// Restarts when stopped, so the first tick is a full period away
	always_comb begin
		cnt_d = cnt_q;
		if (!run) begin
			cnt_d = '0;
		end else if (cnt_q == LAST) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tick = run && (cnt_q == LAST);
endmodule : itc_tick_div
`default_nettype wire

/* hdl/itc_top.sv */
// Interval time counter with time-of-day chain and register port
`default_nettype none
// How it works
// - Two select bits pick tick source: 1/128 s, seconds, minutes, hours.
// - Single-shot set: timeout clears interval enable, counter stops.
// - Single-shot clear: counter reloads at timeout and keeps counting.
// - Interval flag set when counter equals target; held until software clears.
// - Interval enable starts counter; clearing it stops and zeroes counter.
// - Time clock enable runs counters; clearing stops them and zeroes time.
// - Time registers writable while time clock enable is low.
// - Set flag raises interrupt request when interval interrupt enabled.
// - Fraction counts 0..127 each 1/128 s, carry into seconds.
// - Seconds count 0..59, carry into minutes.
// - Minutes count 0..59, carry into hours.
// - Hours count 0..23 then wrap, no carry.
// - Target and all four time registers reset to zero.
// - Interval counter advances once per carry into selected register (the tick itself for 1/128 s).
// - Counters run from the oscillator clock and keep running in power-down.
// - In power-down a set enabled flag wakes device at interval vector.
module itc_top import itc_pkg::*; #(
	parameter int TICK_CYCLES = ITC_TICK_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic irq_enable_prio2,
	input wire logic power_down,
	output logic irq,
	output logic wake,
	output logic [15:0] irq_vector
);
	// ==========================================
	// Helpers
	// One address compare serves every write strobe
	function automatic logic addr_write(
		input logic wr,
		input logic [7:0] addr,
		input logic [7:0] reg_addr
	);
		return wr && (addr == reg_addr);
	endfunction : addr_write

	// Software may only clear the flag; a written one leaves it as it was
	function automatic logic flag_after_write(
		input logic old_flag,
		input logic written
	);
		return old_flag && written;
	endfunction : flag_after_write

	// Interval counter steps on the rollover just below the chosen unit
	function automatic logic pick_advance(
		input itc_base_e sel,
		input logic step_frac,
		input logic step_sec,
		input logic step_min,
		input logic step_hour
	);
		logic step;
		step = 1'b0;
		case (sel)
			ITC_BASE_FRAC: step = step_frac;
			ITC_BASE_SEC: step = step_sec;
			ITC_BASE_MIN: step = step_min;
			ITC_BASE_HOUR: step = step_hour;
			default: step = 1'b0;
		endcase
		return step;
	endfunction : pick_advance

	// Unmapped addresses read as zero
	function automatic logic [7:0] read_mux(
		input logic [7:0] addr,
		input logic [7:0] ctrl_v,
		input logic [7:0] frac_v,
		input logic [7:0] sec_v,
		input logic [7:0] min_v,
		input logic [7:0] hour_v,
		input logic [7:0] target_v
	);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			ITC_ADDR_CTRL: val = ctrl_v;
			ITC_ADDR_FRAC: val = frac_v;
			ITC_ADDR_SEC: val = sec_v;
			ITC_ADDR_MIN: val = min_v;
			ITC_ADDR_HOUR: val = hour_v;
			ITC_ADDR_TARGET: val = target_v;
			default: val = 8'h00;
		endcase
		return val;
	endfunction : read_mux

	// ==========================================
	// Reset release
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// ==========================================
	// Register decode
	logic wr_ctrl;
	logic wr_frac;
	logic wr_sec;
	logic wr_min;
	logic wr_hour;
	logic wr_target;

	assign wr_ctrl = addr_write(sfr_wr, sfr_addr, ITC_ADDR_CTRL);
	assign wr_frac = addr_write(sfr_wr, sfr_addr, ITC_ADDR_FRAC);
	assign wr_sec = addr_write(sfr_wr, sfr_addr, ITC_ADDR_SEC);
	assign wr_min = addr_write(sfr_wr, sfr_addr, ITC_ADDR_MIN);
	assign wr_hour = addr_write(sfr_wr, sfr_addr, ITC_ADDR_HOUR);
	assign wr_target = addr_write(sfr_wr, sfr_addr, ITC_ADDR_TARGET);

	// ==========================================
	// Control and target state
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] target_q;
	logic [7:0] target_d;
	logic [7:0] icnt_q;
	logic [7:0] icnt_d;
	logic time_clock_en_fall;
	logic time_run;
	logic hit_set;
	logic [7:0] icnt_next;
	logic advance;
	itc_base_e base_sel;

	assign base_sel = itc_base_e'(ctrl_q[ITC_BIT_SEL_HI:ITC_BIT_SEL_LO]);
	// Stopping the time clock zeroes the time chain once, later writes then stick
	assign time_clock_en_fall = wr_ctrl && ctrl_q[ITC_BIT_TIME_CLOCK_EN] && !sfr_wdata[ITC_BIT_TIME_CLOCK_EN];
	assign time_run = ctrl_q[ITC_BIT_TIME_CLOCK_EN];

	// ==========================================
	// Timebase and time chain
	logic tick;
	logic frac_wrap;
	logic sec_wrap;
	logic min_wrap;
	logic ld_frac;
	logic ld_sec;
	logic ld_min;
	logic ld_hour;
	logic [7:0] frac_q;
	logic [7:0] sec_q;
	logic [7:0] min_q;
	logic [7:0] hour_q;

	// Loads only stick while the chain is stopped
	assign ld_frac = wr_frac && !time_run;
	assign ld_sec = wr_sec && !time_run;
	assign ld_min = wr_min && !time_run;
	assign ld_hour = wr_hour && !time_run;

	// One clock domain: the oscillator clock drives both register port and counters,
	// so control bits need no crossing and the chain runs through power-down
	itc_tick_div #(.CYCLES(TICK_CYCLES)) u_div (
		.clk(clk),
		.rst_n(rst_n),
		.run(time_run),
		.tick(tick)
	);

	itc_wrap_cnt #(.MAX(ITC_MAX_FRAC)) u_frac (
		.clk(clk),
		.rst_n(rst_n),
		.clr(time_clock_en_fall),
		.ld(ld_frac),
		.ld_val(sfr_wdata),
		.inc(tick),
		.q(frac_q),
		.wrap(frac_wrap)
	);

	itc_wrap_cnt #(.MAX(ITC_MAX_SEC)) u_sec (
		.clk(clk),
		.rst_n(rst_n),
		.clr(time_clock_en_fall),
		.ld(ld_sec),
		.ld_val(sfr_wdata),
		.inc(frac_wrap),
		.q(sec_q),
		.wrap(sec_wrap)
	);

	itc_wrap_cnt #(.MAX(ITC_MAX_MIN)) u_min (
		.clk(clk),
		.rst_n(rst_n),
		.clr(time_clock_en_fall),
		.ld(ld_min),
		.ld_val(sfr_wdata),
		.inc(sec_wrap),
		.q(min_q),
		.wrap(min_wrap)
	);

	// Hour carry is left open on purpose: the day wraps with no further count
	itc_wrap_cnt #(.MAX(ITC_MAX_HOUR)) u_hour (
		.clk(clk),
		.rst_n(rst_n),
		.clr(time_clock_en_fall),
		.ld(ld_hour),
		.ld_val(sfr_wdata),
		.inc(min_wrap),
		.q(hour_q),
		.wrap()
	);

	// ==========================================
	// Interval tick selection
	assign advance = pick_advance(base_sel, tick, frac_wrap, sec_wrap, min_wrap);

	assign icnt_next = icnt_q + 8'h01;
	// Target 0 matches only after a full 256 tick lap
	assign hit_set = ctrl_q[ITC_BIT_INTERVAL_COUNT_EN] && advance && (icnt_next == target_q);

	// ==========================================
	// Control, target and interval counter next state
	always_comb begin
		ctrl_d = ctrl_q;
		target_d = target_q;
		icnt_d = icnt_q;
		if (wr_ctrl) begin
			// Reserved bits are stored and read back; bit 6 is left to software
			ctrl_d = sfr_wdata;
			// Writing zero clears the flag, writing one leaves it
			ctrl_d[ITC_BIT_FLAG] = flag_after_write(ctrl_q[ITC_BIT_FLAG], sfr_wdata[ITC_BIT_FLAG]);
		end
		if (wr_target) begin
			target_d = sfr_wdata;
		end
		if (ctrl_q[ITC_BIT_INTERVAL_COUNT_EN] && advance) begin
			icnt_d = icnt_next;
		end
		if (hit_set) begin
			ctrl_d[ITC_BIT_FLAG] = 1'b1;
			icnt_d = 8'h00;
			if (ctrl_q[ITC_BIT_SHOT]) begin
				ctrl_d[ITC_BIT_INTERVAL_COUNT_EN] = 1'b0;
			end
		end
		if (!ctrl_d[ITC_BIT_INTERVAL_COUNT_EN]) begin
			icnt_d = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= ITC_RST_CTRL;
			target_q <= ITC_RST_TARGET;
			icnt_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			target_q <= target_d;
			icnt_q <= icnt_d;
		end
	end

	// ==========================================
	// Read port
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	always_comb begin
		rdata_d = rdata_q;
		if (sfr_rd) begin
			rdata_d = read_mux(sfr_addr, ctrl_q, frac_q, sec_q, min_q, hour_q, target_q);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;

	// ==========================================
	// Interrupt and wake
	assign irq = ctrl_q[ITC_BIT_FLAG] && irq_enable_prio2;
	assign wake = irq && power_down;
	assign irq_vector = ITC_IRQ_VECTOR;
endmodule : itc_top
`default_nettype wire

/* hdl/itc_wrap_cnt.sv */
// Loadable wrapping time counter with carry out
`default_nettype none
module itc_wrap_cnt import itc_pkg::*; #(
	parameter logic [7:0] MAX = ITC_MAX_SEC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic ld,
	input wire logic [7:0] ld_val,
	input wire logic inc,
	output logic [7:0] q,
	output logic wrap
);
	logic [7:0] q_q;
	logic [7:0] q_d;

	// ==========================================
	// Count
	// Clear beats load beats increment
	always_comb begin
		q_d = q_q;
		if (clr) begin
			q_d = ITC_RST_TIME;
		end else if (ld) begin
			q_d = ld_val;
		end else if (inc) begin
			q_d = (q_q >= MAX) ? 8'h00 : q_q + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_q <= ITC_RST_TIME;
		end else begin
			q_q <= q_d;
		end
	end

	assign q = q_q;
	assign wrap = inc && !clr && !ld && (q_q >= MAX);
endmodule : itc_wrap_cnt
`default_nettype wire

/* verif/interval_time_counter_tb.sv */
// Self-checking bench for the interval time counter
`default_nettype none
module interval_time_counter_tb import itc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Short tick keeps the run small
	localparam int TK = 4;
	logic clk, arst_n, wr, rd, ien, pd, irq, wake;
	logic [7:0] addr, wdat, rdat;
	logic [15:0] vec;
	int err_total = 0;
	int num_checks = 0;
	int n;
	itc_top #(.TICK_CYCLES(TK)) dut (.clk(clk), .arst_n(arst_n), .sfr_addr(addr),
		.sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdat), .sfr_rdata(rdat),
		.irq_enable_prio2(ien), .power_down(pd), .irq(irq), .wake(wake), .irq_vector(vec));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(string s, logic [15:0] g, e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr_reg(logic [7:0] a, d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdat = d;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(logic [7:0] a, e);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		chk("rdata", 16'(rdat), 16'(e));
	endtask : rd_reg
	task automatic wait_irq(int lim);
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_irq
	// ==========
	// Scenarios; every control write keeps bit 6 set
	task automatic t_reset();
		for (int a = 8'hA0; a < 8'hA8; a++) begin
			rd_reg(8'(a), 8'h00);
		end
	endtask : t_reset
	task automatic t_time();
		wr_reg(ITC_ADDR_SEC, ITC_MAX_SEC);
		rd_reg(ITC_ADDR_SEC, ITC_MAX_SEC);
		wr_reg(ITC_ADDR_FRAC, ITC_MAX_FRAC);
		wr_reg(ITC_ADDR_MIN, ITC_MAX_MIN);
		wr_reg(ITC_ADDR_HOUR, ITC_MAX_HOUR);
		wr_reg(ITC_ADDR_CTRL, 8'h41);
		repeat (2 * TK) @(negedge clk);
		rd_reg(ITC_ADDR_HOUR, 8'h00);
		rd_reg(ITC_ADDR_MIN, 8'h00);
		rd_reg(ITC_ADDR_SEC, 8'h00);
		wr_reg(ITC_ADDR_SEC, 8'h05);
		rd_reg(ITC_ADDR_SEC, 8'h00);
		// Carry lands near 129 ticks; reads straddle it by a few cycles
		repeat (129 * TK - 22) @(negedge clk);
		rd_reg(ITC_ADDR_SEC, 8'h00);
		repeat (4) @(negedge clk);
		rd_reg(ITC_ADDR_SEC, 8'h01);
		wr_reg(ITC_ADDR_CTRL, 8'h40);
		rd_reg(ITC_ADDR_SEC, 8'h00);
		rd_reg(ITC_ADDR_FRAC, 8'h00);
	endtask : t_time
	task automatic base_arm(int b, int lv);
		wr_reg(ITC_ADDR_CTRL, 8'h40);
		if (lv > 0) wr_reg(ITC_ADDR_FRAC, ITC_MAX_FRAC);
		if (lv > 1) wr_reg(ITC_ADDR_SEC, ITC_MAX_SEC);
		if (lv > 2) wr_reg(ITC_ADDR_MIN, ITC_MAX_MIN);
		wr_reg(ITC_ADDR_TARGET, 8'h01);
		wr_reg(ITC_ADDR_CTRL, {2'h1, 2'(b), 4'h3});
		wait_irq(2 * TK);
	endtask : base_arm
	task automatic t_base();
		for (int b = 0; b < 4; b++) begin
			// One level short of the chosen unit must stay quiet
			if (b > 0) begin
				base_arm(b, b - 1);
				chk("base early", 16'(irq), 16'h0000);
			end
			base_arm(b, b);
			chk("base irq", 16'(irq), 16'h0001);
		end
	endtask : t_base
	task automatic t_repeat();
		wr_reg(ITC_ADDR_CTRL, 8'h40);
		wr_reg(ITC_ADDR_TARGET, 8'h03);
		rd_reg(ITC_ADDR_TARGET, 8'h03);
		wr_reg(ITC_ADDR_CTRL, 8'h43);
		wait_irq(5 * TK);
		wr_reg(ITC_ADDR_CTRL, 8'h43);
		wait_irq(5 * TK);
		chk("gap", 16'(n), 16'(3 * TK - 2));
		ien = 1'b0;
		@(negedge clk);
		chk("masked", 16'(irq), 16'h0000);
		ien = 1'b1;
		pd = 1'b1;
		@(negedge clk);
		chk("wake", 16'(wake), 16'h0001);
		chk("vector", vec, 16'h0053);
		pd = 1'b0;
		repeat (TK) @(negedge clk);
		wr_reg(ITC_ADDR_CTRL, 8'h41);
		wr_reg(ITC_ADDR_CTRL, 8'h43);
		wait_irq(5 * TK);
		chk("restart", 16'(n > 2 * TK), 16'h0001);
		chk("restart irq", 16'(irq), 16'h0001);
	endtask : t_repeat
	task automatic t_single();
		wr_reg(ITC_ADDR_CTRL, 8'h40);
		wr_reg(ITC_ADDR_CTRL, 8'h4B);
		wait_irq(4 * TK);
		rd_reg(ITC_ADDR_CTRL, 8'h4D);
		// Write back what was read, flag cleared, so a kept enable would fire again
		wr_reg(ITC_ADDR_CTRL, rdat & 8'hFB);
		repeat (4 * TK) @(negedge clk);
		chk("shot irq", 16'(irq), 16'h0000);
	endtask : t_single
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict
	// ==========
	// Watchdog and main sequence
	initial begin
		#50us;
		err_total++;
		print_verdict();
	end
	initial begin
		arst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdat = 8'h00;
		ien = 1'b1;
		pd = 1'b0;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_reset();
		t_time();
		t_base();
		t_repeat();
		t_single();
		print_verdict();
	end
endmodule : interval_time_counter_tb
`default_nettype wire

/* verif/itc_monitor.sv */
// Port checker for the interval time counter
`default_nettype none
module itc_monitor import itc_pkg::*; #(
	parameter int TICK_CYCLES = ITC_TICK_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic irq_enable_prio2,
	input wire logic power_down,
	input wire logic irq,
	input wire logic wake,
	input wire logic [15:0] irq_vector
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Time clock enable as last written; hardware never changes it
	logic time_clock_en_q;
	logic time_clock_en_d;
	always_comb begin
		time_clock_en_d = time_clock_en_q;
		if (sfr_wr && sfr_addr == ITC_ADDR_CTRL) begin
			time_clock_en_d = sfr_wdata[ITC_BIT_TIME_CLOCK_EN];
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			time_clock_en_q <= 1'b0;
		end else begin
			time_clock_en_q <= time_clock_en_d;
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_wr_rd(a);
		sfr_wr && sfr_addr == a ##1 !sfr_wr ##1 sfr_rd && !sfr_wr && sfr_addr == a;
	endsequence
	a_reset_clear: assert property ($rose(arst_n) |-> sfr_rdata == 8'h00 && !irq)
		else $error("output set after reset");
	a_target_back: assert property (s_wr_rd(ITC_ADDR_TARGET) |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("target read back wrong");
	a_time_load: assert property (!time_clock_en_q ##0 s_wr_rd(ITC_ADDR_SEC) |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("stopped time write lost");
	a_flag_held: assert property (irq && !(sfr_wr && sfr_addr == ITC_ADDR_CTRL) ##1 irq_enable_prio2 |-> irq)
		else $error("flag dropped by itself");
	a_irq_gate: assert property (irq |-> irq_enable_prio2)
		else $error("irq while disabled");
	a_wake_cond: assert property (wake == (irq && power_down))
		else $error("wake wrong");
	a_vector_fixed: assert property (irq_vector == ITC_IRQ_VECTOR)
		else $error("vector wrong");
	a_tick_needs_clk: assert property ($rose(irq) && $stable(irq_enable_prio2) |-> $past(time_clock_en_q))
		else $error("flag set with clock off");
endmodule : itc_monitor
bind itc_top itc_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.clk(clk), .arst_n(arst_n),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .irq_enable_prio2(irq_enable_prio2), .power_down(power_down),
	.irq(irq), .wake(wake), .irq_vector(irq_vector));
`default_nettype wire
